/* File: hdl/pcr_top.sv */
// Clock source routing and PLL control configuration with APB register access
//
// The implementer's own choice: register access over APB.
`include "pcr_defines.svh"

module pcr_top
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`PCR_AW-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // PLL control
  output logic                     pll_power_down,
  output logic                     pll_running,
  output logic                     pfd_pol_neg,
  // Distribution routing
  output logic      [2:0]          vco_div_ratio,
  output logic                     div_bypass,
  output logic                     dist_src_vco,
  // Calibration
  output logic                     vco_cal_start
);

  // Register hit, one-hot: pwr, cal, div, src, sts, upd
  function automatic logic [5:0] reg_hit(input logic [`PCR_AW-1:0] a);
    logic [9:0] idx;
    idx = a[`PCR_AW-1:2];
    reg_hit = 6'h00;
    if (a[1:0] == 2'h0) begin
      reg_hit[0] = (idx == `PCR_IDX_PWR);
      reg_hit[1] = (idx == `PCR_IDX_CAL);
      reg_hit[2] = (idx == `PCR_IDX_DIV);
      reg_hit[3] = (idx == `PCR_IDX_SRC);
      reg_hit[4] = (idx == `PCR_IDX_STS);
      reg_hit[5] = (idx == `PCR_IDX_UPD);
    end
  endfunction : reg_hit

  // Divider code to ratio; codes above divide-by-6 saturate there
  function automatic logic [2:0] div_factor(input logic [2:0] code);
    case (code)
      `PCR_DIV_CODE_2: div_factor = 3'h2;
      `PCR_DIV_CODE_3: div_factor = 3'h3;
      `PCR_DIV_CODE_4: div_factor = 3'h4;
      `PCR_DIV_CODE_5: div_factor = 3'h5;
      default:         div_factor = `PCR_DIV_MAX;
    endcase
  endfunction : div_factor

  pcr_cfg_if cfg ();

  pcr_top_s    s_r;
  pcr_top_s    s_nxt;
  logic [5:0]  hit;
  logic        setup;
  logic        commit;
  logic        wr_ok;
  logic [31:0] rd_word;
  pcr_sel_e    sel;

  // Bus phase decode
  assign hit    = reg_hit(paddr);
  assign setup  = psel && !penable;
  assign commit = psel && penable && s_r.pready;
  // Only lane 0 carries register data, so a write without it is dropped
  assign wr_ok  = commit && pwrite && !s_r.pslverr && pstrb[0];

  // Byte register select
  always_comb begin
    case (hit[3:0])
      4'h1:    sel = PCR_SEL_PWR;
      4'h2:    sel = PCR_SEL_CAL;
      4'h4:    sel = PCR_SEL_DIV;
      4'h8:    sel = PCR_SEL_SRC;
      default: sel = PCR_SEL_NONE;
    endcase
  end

  // Read data; byte register reads show the staged values so software sees its writes, status shows the applied ones
  always_comb begin
    rd_word = 32'h0000_0000;
    case (1'b1)
      hit[0]:  rd_word = {24'h00_0000, cfg.shadow.pwr};
      hit[1]:  rd_word = {24'h00_0000, cfg.shadow.cal};
      hit[2]:  rd_word = {24'h00_0000, cfg.shadow.div};
      hit[3]:  rd_word = {24'h00_0000, cfg.shadow.src};
      hit[4]:  rd_word = {cfg.active.pwr, cfg.active.div, cfg.active.src,
                          7'h00, cfg.pending};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign cfg.wr    = wr_ok && (sel != PCR_SEL_NONE);
  assign cfg.wsel  = sel;
  assign cfg.wdata = pwdata[7:0];
  assign cfg.upd   = s_r.upd;

  // Next state of bus answer and control outputs
  always_comb begin
    s_nxt = s_r;
    // Answer in the first cycle of the access phase
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = (hit == 6'h00);
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
    end
    s_nxt.upd = wr_ok && hit[5] && pwdata[`PCR_UPD_BIT];
    s_nxt.pll_pd = (cfg.active.pwr[`PCR_PWR_MSB:`PCR_PWR_LSB] == `PCR_PWR_ASYNC_PD);
    s_nxt.pll_on = (cfg.active.pwr[`PCR_PWR_MSB:`PCR_PWR_LSB] == `PCR_PWR_ON);
    s_nxt.pol_neg = cfg.active.pwr[`PCR_POL_BIT];
    s_nxt.div_ratio = div_factor(cfg.active.div[`PCR_DIV_MSB:0]);
    s_nxt.byp = cfg.active.src[`PCR_BYP_BIT];
    s_nxt.src_vco = cfg.active.src[`PCR_SRC_BIT];
    // start on rising calibration bit at an update
    s_nxt.cal_start = cfg.applied && cfg.active.cal[`PCR_CAL_BIT] && !s_r.cal_prev;
    if (cfg.applied) begin
      // a later run needs the bit applied clear first
      s_nxt.cal_prev = cfg.active.cal[`PCR_CAL_BIT];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, upd: 1'b0,
               pll_pd: 1'b1, pll_on: 1'b0, pol_neg: 1'b0, div_ratio: 3'h4,
               byp: 1'b0, src_vco: 1'b0, cal_start: 1'b0, cal_prev: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Staged configuration bank
  pcr_shadow_bank u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg.bank)
  );

  // Outputs straight from the state register
  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign pll_power_down = s_r.pll_pd;
  assign pll_running    = s_r.pll_on;
  assign pfd_pol_neg    = s_r.pol_neg;
  assign vco_div_ratio  = s_r.div_ratio;
  assign div_bypass     = s_r.byp;
  assign dist_src_vco   = s_r.src_vco;
  assign vco_cal_start  = s_r.cal_start;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Calibration arming seen from the bank
  sequence cal_armed_s;
    cfg.applied && cfg.active.cal[`PCR_CAL_BIT] && !s_r.cal_prev;
  endsequence

  sequence cal_pulse_s;
    vco_cal_start ##1 !vco_cal_start;
  endsequence

  pll_on_a : assert property (
    (cfg.active.pwr[1:0] == `PCR_PWR_ON) |=> pll_running && !pll_power_down)
    else $error("PLL not running with power field 00");

  pll_off_a : assert property (
    (cfg.active.pwr[1:0] == `PCR_PWR_ASYNC_PD) |=> pll_power_down && !pll_running)
    else $error("PLL not powered down with power field 01");

  div_four_a : assert property (
    (cfg.active.div[2:0] == `PCR_DIV_CODE_4) |=> (vco_div_ratio == 3'h4))
    else $error("divider code 010 does not give divide-by-4");

  div_range_a : assert property (
    (vco_div_ratio >= `PCR_DIV_MIN) && (vco_div_ratio <= `PCR_DIV_MAX))
    else $error("divider ratio outside 2 to 6");

  div_path_a : assert property (
    !cfg.active.src[`PCR_BYP_BIT] |=> !div_bypass)
    else $error("divider bypassed while bypass bit clear");

  div_skip_a : assert property (
    cfg.active.src[`PCR_BYP_BIT] |=> div_bypass)
    else $error("divider in path while bypass bit set");

  src_vco_a : assert property (
    cfg.active.src[`PCR_SRC_BIT] |=> dist_src_vco)
    else $error("VCO not routed with source bit set");

  src_ext_a : assert property (
    !cfg.active.src[`PCR_SRC_BIT] |=> !dist_src_vco)
    else $error("external clock not routed with source bit clear");

  pol_pos_a : assert property (
    !cfg.active.pwr[`PCR_POL_BIT] |=> !pfd_pol_neg)
    else $error("polarity negative while bit clear");

  pol_neg_a : assert property (
    cfg.active.pwr[`PCR_POL_BIT] |=> pfd_pol_neg)
    else $error("polarity positive while bit set");

  cal_go_a : assert property (
    cal_armed_s |=> cal_pulse_s)
    else $error("calibration not started on armed update");

  cal_cause_a : assert property (
    vco_cal_start |-> $past(cfg.applied))
    else $error("calibration started without an update");

  upd_apply_a : assert property (
    commit && pwrite && hit[5] && pwdata[0] && pstrb[0] |=> ##1 cfg.applied)
    else $error("update write not applied two edges later");

  // Bus answer steps: setup edge, then ready for exactly one cycle
  sequence bus_setup_s;
    psel && !penable;
  endsequence

  sequence bus_answer_s;
    pready ##1 !pready;
  endsequence

  bus_answer_a : assert property (
    bus_setup_s |=> bus_answer_s)
    else $error("bus answer not a single ready cycle after setup");

  bus_unmapped_a : assert property (
    setup && (hit == 6'h00) |=> pready && pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused with zero data");

  strobe_drop_a : assert property (
    commit && pwrite && !pstrb[0] |=> $stable(cfg.shadow))
    else $error("write without lane 0 strobe changed a staged value");

  shadow_div_a : assert property (
    cfg.wr && (cfg.wsel == PCR_SEL_DIV) |=> (cfg.shadow.div == $past(cfg.wdata)))
    else $error("divider write not staged");

  shadow_pwr_a : assert property (
    cfg.wr && (cfg.wsel == PCR_SEL_PWR) |=> (cfg.shadow.pwr == $past(cfg.wdata)))
    else $error("power write not staged");

  read_staged_a : assert property (
    setup && !pwrite && hit[3] |=> (prdata == {24'h00_0000, $past(cfg.shadow.src)}))
    else $error("source read does not show the staged value");

  upd_ignored_a : assert property (
    commit && pwrite && hit[5] && !pwdata[`PCR_UPD_BIT] |=> !cfg.upd)
    else $error("update strobe taken with bit 0 clear");

  route_hold_a : assert property (
    !cfg.applied |=> $stable(vco_div_ratio) && $stable(div_bypass) &&
                     $stable(dist_src_vco) && $stable(pll_running) &&
                     $stable(pll_power_down) && $stable(pfd_pol_neg))
    else $error("routing output changed without an update");

  pll_unused_a : assert property (
    cfg.active.pwr[1] |=> !pll_running && !pll_power_down)
    else $error("power codes 10 or 11 drive a power output");

  div_six_a : assert property (
    cfg.active.div[2] |=> (vco_div_ratio == `PCR_DIV_MAX))
    else $error("divider codes 100 to 111 do not give divide-by-6");

  cal_once_a : assert property (
    cfg.applied && s_r.cal_prev |=> !vco_cal_start)
    else $error("calibration restarted without the bit applied clear");

  cal_idle_a : assert property (
    !cfg.applied |=> !vco_cal_start)
    else $error("calibration pulse outside an update");

endmodule : pcr_top

/* File: include/pcr_defines.svh */
// Register indices, field positions, reset values and codes for the clock routing block
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// APB address width; byte address is four times the register index
`define PCR_AW            12

// Register indices
`define PCR_IDX_PWR       10'h010
`define PCR_IDX_CAL       10'h018
`define PCR_IDX_DIV       10'h1e0
`define PCR_IDX_SRC       10'h1e1
`define PCR_IDX_STS       10'h230
`define PCR_IDX_UPD       10'h232

// Field positions
`define PCR_PWR_LSB       0
`define PCR_PWR_MSB       1
`define PCR_POL_BIT       7
`define PCR_CAL_BIT       0
`define PCR_DIV_MSB       2
`define PCR_BYP_BIT       0
`define PCR_SRC_BIT       1
`define PCR_UPD_BIT       0

// Power field codes
`define PCR_PWR_ON        2'h0
`define PCR_PWR_ASYNC_PD  2'h1

// Divider codes and the ratios they give
`define PCR_DIV_CODE_2    3'h0
`define PCR_DIV_CODE_3    3'h1
`define PCR_DIV_CODE_4    3'h2
`define PCR_DIV_CODE_5    3'h3
`define PCR_DIV_MIN       3'h2
`define PCR_DIV_MAX       3'h6

// Reset values
`define PCR_RST_PWR       8'h01
`define PCR_RST_CAL       8'h00
`define PCR_RST_DIV       8'h02
`define PCR_RST_SRC       8'h00

`endif

/* File: include/pcr_pkg.sv */
// Types shared by the clock routing configuration modules
package pcr_pkg;

  typedef logic [7:0] pcr_byte_t;

  // One byte per configuration register
  typedef struct packed {
    pcr_byte_t pwr;
    pcr_byte_t cal;
    pcr_byte_t div;
    pcr_byte_t src;
  } pcr_cfg_s;

  // Register select, one-hot
  typedef enum logic [3:0] {
    PCR_SEL_NONE = 4'b0000,
    PCR_SEL_PWR  = 4'b0001,
    PCR_SEL_CAL  = 4'b0010,
    PCR_SEL_DIV  = 4'b0100,
    PCR_SEL_SRC  = 4'b1000
  } pcr_sel_e;

  // Shadow bank state
  typedef struct packed {
    pcr_cfg_s shadow;
    pcr_cfg_s active;
    logic     pending;
    logic     applied;
  } pcr_bank_s;

  // Top level state
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        upd;
    logic        pll_pd;
    logic        pll_on;
    logic        pol_neg;
    logic [2:0]  div_ratio;
    logic        byp;
    logic        src_vco;
    logic        cal_start;
    logic        cal_prev;
  } pcr_top_s;

endpackage : pcr_pkg

/* File: include/pcr_cfg_if.sv */
// Carrier between the bus front end and the shadow register bank
interface pcr_cfg_if;
  import pcr_pkg::*;

  logic             wr;
  pcr_sel_e         wsel;
  pcr_byte_t        wdata;
  logic             upd;
  pcr_cfg_s         shadow;
  pcr_cfg_s         active;
  logic             pending;
  logic             applied;

  modport ctl  (output wr, wsel, wdata, upd, input shadow, active, pending, applied);
  modport bank (input wr, wsel, wdata, upd, output shadow, active, pending, applied);
endinterface : pcr_cfg_if

/* File: hdl/pcr_shadow_bank.sv */
// Shadow and active copies of the configuration registers
`include "pcr_defines.svh"

module pcr_shadow_bank
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Carrier to the bus front end
  pcr_cfg_if.bank   cfg
);

  localparam pcr_cfg_s RST_CFG = '{pwr: `PCR_RST_PWR, cal: `PCR_RST_CAL,
                                   div: `PCR_RST_DIV, src: `PCR_RST_SRC};

  pcr_bank_s s_r;
  pcr_bank_s s_nxt;

  // Stage writes; copy everything at once on update
  always_comb begin
    s_nxt = s_r;
    s_nxt.applied = 1'b0;
    if (cfg.wr) begin
      case (cfg.wsel)
        PCR_SEL_PWR: s_nxt.shadow.pwr = cfg.wdata;
        PCR_SEL_CAL: s_nxt.shadow.cal = cfg.wdata;
        PCR_SEL_DIV: s_nxt.shadow.div = cfg.wdata;
        PCR_SEL_SRC: s_nxt.shadow.src = cfg.wdata;
        default:     s_nxt.shadow = s_r.shadow;
      endcase
      s_nxt.pending = 1'b1;
    end
    if (cfg.upd) begin
      s_nxt.active  = s_r.shadow;
      // A write landing with the update stays pending: set wins over clear
      s_nxt.pending = cfg.wr;
      s_nxt.applied = 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{shadow: RST_CFG, active: RST_CFG, pending: 1'b0, applied: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg.shadow  = s_r.shadow;
  assign cfg.active  = s_r.active;
  assign cfg.pending = s_r.pending;
  assign cfg.applied = s_r.applied;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  shadow_transfer_a : assert property (
    cfg.upd |=> (cfg.active == $past(cfg.shadow)) && cfg.applied &&
                (cfg.pending == $past(cfg.wr)))
    else $error("active copy not loaded from shadow after update");

  staged_hold_a : assert property (
    !cfg.upd |=> $stable(cfg.active) && !cfg.applied)
    else $error("active copy changed without an update");

endmodule : pcr_shadow_bank

/* File: bench/pcr_top_test.sv */
// Self-checking bench for the clock routing configuration block
`include "pcr_defines.svh"

module pcr_top_test
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rv;
  logic [3:0]  pstrb;
  logic        pll_power_down, pll_running, pfd_pol_neg;
  logic        div_bypass, dist_src_vco, vco_cal_start, err, pend, cal_exp;
  logic [2:0]  vco_div_ratio;
  logic [7:0]  sh [4];
  logic [7:0]  ac [4];
  int          fails, checks, seed, k, i;

  // Byte addresses: power, calibration, divider, source, status, update
  localparam logic [11:0] AD [4] = '{{`PCR_IDX_PWR, 2'h0}, {`PCR_IDX_CAL, 2'h0},
                                     {`PCR_IDX_DIV, 2'h0}, {`PCR_IDX_SRC, 2'h0}};
  localparam logic [11:0] STS = {`PCR_IDX_STS, 2'h0};
  localparam logic [11:0] UPD = {`PCR_IDX_UPD, 2'h0};

  pcr_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_power_down(pll_power_down), .pll_running(pll_running),
    .pfd_pol_neg(pfd_pol_neg), .vco_div_ratio(vco_div_ratio), .div_bypass(div_bypass),
    .dist_src_vco(dist_src_vco), .vco_cal_start(vco_cal_start)
  );

  // Free-running bus clock
  always #4 pclk = ~pclk;

  task end_sim;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; an idle cycle always separates transfers
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the answer; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Staged write; upper data bits carry noise the block must ignore
  task wreg(input int r, input logic [7:0] v);
    logic [31:0] rnd;
    rnd = $random(seed);
    apb(1'b1, AD[r], {rnd[31:8], v}, 4'hf);
    sh[r] = v;
    pend = 1'b1;
    chk("wr_err", err, 0);
  endtask : wreg

  task rreg(input int r);
    apb(1'b0, AD[r], 32'h0, 4'hf);
    chk("rd_data", rd, sh[r]);
    chk("rd_err", err, 0);
  endtask : rreg

  // Compare every routing output with the applied model copy
  task outs;
    chk("pd", pll_power_down, ac[0][1:0] == 2'h1);
    chk("run", pll_running, ac[0][1:0] == 2'h0);
    chk("pol", pfd_pol_neg, ac[0][7]);
    chk("div", vco_div_ratio, (ac[2][2:0] < 3'h4) ? ac[2][2:0] + 3'h2 : 3'h6);
    chk("byp", div_bypass, ac[3][0]);
    chk("src", dist_src_vco, ac[3][1]);
    apb(1'b0, STS, 32'h0, 4'hf);
    chk("sts", rd, {ac[0], ac[2], ac[3], 7'h0, pend});
  endtask : outs

  // Update write; a calibration pulse is due on a 0 to 1 change of the applied bit
  task upd(input logic [31:0] d);
    apb(1'b1, UPD, d, 4'hf);
    cal_exp = 1'b0;
    if (d[0]) begin
      cal_exp = sh[1][0] & ~ac[1][0];
      ac = sh;
      pend = 1'b0;
    end
    @(posedge pclk);
    @(posedge pclk);
    #1;
    chk("cal_pulse", vco_cal_start, cal_exp);
    @(posedge pclk);
    #1;
    chk("cal_end", vco_cal_start, 0);
    outs();
  endtask : upd

  // Hang guard, well beyond the expected run length
  initial begin
    #400000;
    fails++;
    end_sim();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {fails, checks} = 0;
    seed = 2;
    pend = 1'b0;
    sh = '{`PCR_RST_PWR, `PCR_RST_CAL, `PCR_RST_DIV, `PCR_RST_SRC};
    ac = sh;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("rst_cal", vco_cal_start, 0);
    outs();
    for (i = 0; i < 4; i++)
      rreg(i);
    // Staged values stay invisible until a proper update
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      wreg(i, rv[7:0]);
    end
    outs();
    for (i = 0; i < 4; i++)
      rreg(i);
    upd(32'h2);
    // Disabled strobe and unmapped or misaligned places change nothing
    apb(1'b1, AD[2], 32'h7, 4'he);
    rreg(2);
    apb(1'b1, 12'h004, 32'hff, 4'hf);
    chk("unm_err", err, 1);
    apb(1'b0, 12'h041, 32'h0, 4'hf);
    chk("mis_err", err, 1);
    chk("mis_rd", rd, 0);
    apb(1'b1, STS, 32'hff, 4'hf);
    chk("sts_wr_err", err, 0);
    apb(1'b0, UPD, 32'h0, 4'hf);
    chk("upd_rd", rd, 0);
    outs();
    // Every power and divider code, then random set-ups; calibration bit raised twice, then held high over four updates
    for (k = 0; k < 16; k++) begin
      // Own variable: the bus task overwrites rd with each answer
      rv = $random(seed);
      wreg(0, (k < 8) ? {rv[7:2], k[1:0]} : rv[7:0]);
      wreg(2, (k < 8) ? {rv[15:11], k[2:0]} : rv[15:8]);
      // Software never bypasses the divider with the internal VCO selected
      wreg(3, {rv[23:18], rv[17], rv[16] & ~rv[17]});
      wreg(1, (k < 8) ? {rv[31:25], k[0] | k[2]} : rv[31:24]);
      upd(32'h1);
    end
    // Internal VCO set-up with a proper recalibration, then the external bypass routing with the PLL powered down, then running
    for (k = 0; k < 2; k++) begin
      wreg(1, 8'h00);
      upd(32'h1);
      wreg(0, 8'h00);
      wreg(2, 8'h03);
      wreg(3, 8'h02);
      wreg(1, 8'h01);
      upd(32'h1);
    end
    wreg(0, 8'h01);
    wreg(3, 8'h01);
    upd(32'h1);
    wreg(0, 8'h80);
    upd(32'h1);
    end_sim();
  end
endmodule : pcr_top_test
